// [core/auth_codec_consts.svh]
// Overview of operation
// - Request type 0x40, reply type 0x41
// - Message type octet top bit zero
// - Portable request: key type plus challenge
// - Fixed request: key type, seed, challenge
// - Replies: portable first response; fixed seed, second
// - Portable request response only in key allocation
// - Value MSB in bit 8, octet 3
// - LSB in octet 10, response octet 6
// - Element identifiers 0x0C, 0x0D, 0x0E, 0x0A
// - Element sizes 10, 6, 10, 5 bytes
// - Receiver skips unrelated elements
// - Auth key bound to identity or identity plus park
// - At most one personal value per key
// - Keys selected by own key number
// - Derived cipher key inherits auth key identity
// - Static cipher key bound identity or pair
// - Fixed side releases call on first response mismatch
// - Portable side releases call on second response mismatch
`ifndef AUTH_CODEC_CONSTS_SVH
`define AUTH_CODEC_CONSTS_SVH
`define MSG_AUTH_REQUEST 8'h0040
`define MSG_AUTH_REPLY 8'h0041
`define MSG_TYPE_MSB 7
`define EI_CHALLENGE 8'h000C
`define EI_RESPONSE 8'h000D
`define EI_SEED 8'h000E
`define EI_KEY_TYPE 8'h000A
`define LEN_CHALLENGE 8'h0008
`define LEN_RESPONSE 8'h0004
`define LEN_SEED 8'h0008
`define LEN_KEY_TYPE 8'h0003
`define FRAME_BYTES 32
`define KEY_ENTRIES 4
`define IDENTITY_RESET 8'h0000
`endif

// [core/auth_codec_pkg.sv]
package auth_codec_pkg;
   // Receive parser states
   typedef enum logic [2:0] {RX_TYPE, RX_ID, RX_LEN, RX_BODY, RX_DROP} rx_state_t;
   // Transmit states
   typedef enum logic [0:0] {TX_IDLE, TX_SEND} tx_state_t;
endpackage : auth_codec_pkg

// [core/auth_message_codec.sv]
`timescale 1ns/1ns
`default_nettype none
`include "auth_codec_consts.svh"
module auth_message_codec (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // Role strap, high for the fixed side
   input wire logic IS_FIXED_SIDE,
   // Message build request
   input wire logic BUILD_START,
   input wire logic BUILD_REPLY,
   input wire logic BUILD_KEY_ALLOC,
   input wire logic [23:0] BUILD_KEY_TYPE,
   input wire logic [63:0] BUILD_CHALLENGE,
   input wire logic [63:0] BUILD_SEED,
   input wire logic [31:0] BUILD_RESPONSE,
   output logic BUILD_BUSY,
   // Outgoing byte stream
   output logic [7:0] TX_DATA,
   output logic TX_VALID,
   output logic TX_LAST,
   input wire logic TX_READY,
   // Incoming byte stream
   input wire logic [7:0] RX_DATA,
   input wire logic RX_VALID,
   input wire logic RX_LAST,
   // Parse results
   output logic RX_DONE,
   output logic RX_ERROR,
   output logic RX_IS_REPLY,
   output logic [23:0] RX_KEY_TYPE,
   output logic [63:0] RX_CHALLENGE,
   output logic [63:0] RX_SEED,
   output logic [31:0] RX_RESPONSE,
   output logic RX_HAS_RESPONSE,
   // Response check
   input wire logic [31:0] EXPECTED_RESPONSE,
   output logic RELEASE_CALL,
   // Key binding table
   input wire logic KEY_WRITE,
   input wire logic KEY_CIPHER,
   input wire logic KEY_DERIVE,
   input wire logic [1:0] KEY_NUM,
   input wire logic [1:0] KEY_SRC_NUM,
   input wire logic [7:0] KEY_IDENTITY,
   input wire logic KEY_WITH_PARK,
   input wire logic KEY_PIN_BIND,
   output logic KEY_REFUSED,
   input wire logic [1:0] KEY_SEL,
   input wire logic KEY_SEL_CIPHER,
   output logic [7:0] SEL_IDENTITY,
   output logic SEL_WITH_PARK,
   output logic SEL_PIN_BOUND,
   output logic SEL_VALID
);
   logic fixed_meta_reg;
   logic fixed_reg;
   logic [7:0] frame_reg [0:`FRAME_BYTES-1];
   logic [7:0] frame_next [0:`FRAME_BYTES-1];
   int frame_len_next;
   logic [5:0] frame_len_reg;
   logic [5:0] tx_idx_reg;
   auth_codec_pkg::tx_state_t tx_state_reg;
   auth_codec_pkg::rx_state_t rx_state_reg;
   logic [7:0] el_id_reg;
   logic [7:0] el_left_reg;
   logic [63:0] el_shift_reg;
   logic el_bad_reg;
   logic [3:0] seen_reg;
   logic frame_bad_reg;
   logic rx_end;
   logic [3:0] seen_next;
   logic need_ok;
   logic [7:0] want_len;
   logic known_id;

   // Strap crosses from a pin, so two flops first
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         fixed_meta_reg <= 1'b0;
         fixed_reg <= 1'b0;
      end else begin
         fixed_meta_reg <= IS_FIXED_SIDE;
         fixed_reg <= fixed_meta_reg;
      end
   end

   // Frame assembly, values sent most significant byte first
   always_comb begin
      int n;
      n = 0;
      for (int i = 0; i < `FRAME_BYTES; i++) begin
         frame_next[i] = frame_reg[i];
      end
      frame_next[n] = BUILD_REPLY ? `MSG_AUTH_REPLY : `MSG_AUTH_REQUEST;
      n = n + 1;
      if (!BUILD_REPLY) begin
         frame_next[n] = `EI_KEY_TYPE;
         frame_next[n+1] = `LEN_KEY_TYPE;
         for (int k = 0; k < 3; k++) begin
            frame_next[n+2+k] = BUILD_KEY_TYPE[8*(2-k)+:8];
         end
         n = n + 5;
      end
      if (fixed_reg) begin
         frame_next[n] = `EI_SEED;
         frame_next[n+1] = `LEN_SEED;
         for (int k = 0; k < 8; k++) begin
            frame_next[n+2+k] = BUILD_SEED[8*(7-k)+:8];
         end
         n = n + 10;
      end
      if (!BUILD_REPLY) begin
         frame_next[n] = `EI_CHALLENGE;
         frame_next[n+1] = `LEN_CHALLENGE;
         for (int k = 0; k < 8; k++) begin
            frame_next[n+2+k] = BUILD_CHALLENGE[8*(7-k)+:8];
         end
         n = n + 10;
      end
      // Response goes in replies, and in portable requests only for key allocation
      if (BUILD_REPLY || (!fixed_reg && BUILD_KEY_ALLOC)) begin
         frame_next[n] = `EI_RESPONSE;
         frame_next[n+1] = `LEN_RESPONSE;
         for (int k = 0; k < 4; k++) begin
            frame_next[n+2+k] = BUILD_RESPONSE[8*(3-k)+:8];
         end
         n = n + 6;
      end
      frame_len_next = n;
   end

   // Frame store, loaded only while idle so a frame in flight is never torn
   always_ff @(posedge CLK) begin
      if (tx_state_reg == auth_codec_pkg::TX_IDLE && BUILD_START) begin
         for (int i = 0; i < `FRAME_BYTES; i++) begin
            frame_reg[i] <= frame_next[i];
         end
      end
   end

   // Transmit sequencer
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         tx_state_reg <= auth_codec_pkg::TX_IDLE;
         tx_idx_reg <= 6'h00;
         frame_len_reg <= 6'h00;
      end else begin
         case (tx_state_reg)
            auth_codec_pkg::TX_IDLE: begin
               if (BUILD_START) begin
                  tx_state_reg <= auth_codec_pkg::TX_SEND;
                  tx_idx_reg <= 6'h00;
                  frame_len_reg <= 6'(frame_len_next);
               end
            end
            auth_codec_pkg::TX_SEND: begin
               if (TX_READY) begin
                  if (tx_idx_reg == frame_len_reg - 6'h01) begin
                     tx_state_reg <= auth_codec_pkg::TX_IDLE;
                  end
                  tx_idx_reg <= tx_idx_reg + 6'h01;
               end
            end
            default: tx_state_reg <= auth_codec_pkg::TX_IDLE;
         endcase
      end
   end

   // Stream outputs; data is a mux of stored bytes
   assign TX_VALID = (tx_state_reg == auth_codec_pkg::TX_SEND);
   assign TX_LAST = TX_VALID && (tx_idx_reg == frame_len_reg - 6'h01);
   assign TX_DATA = TX_VALID ? frame_reg[tx_idx_reg[4:0]] : 8'h00;
   assign BUILD_BUSY = TX_VALID;

   // Expected content length per element; unknown ids are not checked
   always_comb begin
      known_id = 1'b1;
      case (el_id_reg)
         `EI_CHALLENGE: want_len = `LEN_CHALLENGE;
         `EI_SEED: want_len = `LEN_SEED;
         `EI_RESPONSE: want_len = `LEN_RESPONSE;
         `EI_KEY_TYPE: want_len = `LEN_KEY_TYPE;
         default: begin
            want_len = 8'h00;
            known_id = 1'b0;
         end
      endcase
   end

   // Presence flags after the byte under way: key type, seed, challenge, response
   always_comb begin
      seen_next = seen_reg;
      if (rx_state_reg == auth_codec_pkg::RX_BODY && el_left_reg == 8'h01 && !el_bad_reg) begin
         case (el_id_reg)
            `EI_KEY_TYPE: seen_next[0] = 1'b1;
            `EI_SEED: seen_next[1] = 1'b1;
            `EI_CHALLENGE: seen_next[2] = 1'b1;
            `EI_RESPONSE: seen_next[3] = 1'b1;
            default: seen_next = seen_reg;
         endcase
      end
   end

   // Required elements depend on who sent it: the peer has the opposite role
   always_comb begin
      if (!RX_IS_REPLY) begin
         need_ok = seen_next[0] && seen_next[2] && (fixed_reg || seen_next[1]);
      end else begin
         need_ok = seen_next[3] && (fixed_reg || seen_next[1]);
      end
   end

   assign rx_end = RX_VALID && RX_LAST;

   // Parser: type octet, then id, length, body per element
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         rx_state_reg <= auth_codec_pkg::RX_TYPE;
         el_id_reg <= 8'h00;
         el_left_reg <= 8'h00;
         el_shift_reg <= 64'h0000_0000_0000_0000;
         el_bad_reg <= 1'b0;
         seen_reg <= 4'h0;
         frame_bad_reg <= 1'b0;
         RX_DONE <= 1'b0;
         RX_ERROR <= 1'b0;
         RX_IS_REPLY <= 1'b0;
         RX_KEY_TYPE <= 24'h00_0000;
         RX_CHALLENGE <= 64'h0000_0000_0000_0000;
         RX_SEED <= 64'h0000_0000_0000_0000;
         RX_RESPONSE <= 32'h0000_0000;
         RX_HAS_RESPONSE <= 1'b0;
      end else begin
         RX_DONE <= 1'b0;
         RX_ERROR <= 1'b0;
         if (RX_VALID) begin
            seen_reg <= seen_next;
            case (rx_state_reg)
               auth_codec_pkg::RX_TYPE: begin
                  seen_reg <= 4'h0;
                  RX_IS_REPLY <= (RX_DATA == `MSG_AUTH_REPLY);
                  // Top bit set or unknown code spoils the frame
                  frame_bad_reg <= RX_DATA[`MSG_TYPE_MSB] ||
                     (RX_DATA != `MSG_AUTH_REQUEST && RX_DATA != `MSG_AUTH_REPLY);
                  rx_state_reg <= auth_codec_pkg::RX_ID;
               end
               auth_codec_pkg::RX_ID: begin
                  el_id_reg <= RX_DATA;
                  rx_state_reg <= auth_codec_pkg::RX_LEN;
               end
               auth_codec_pkg::RX_LEN: begin
                  el_left_reg <= RX_DATA;
                  el_shift_reg <= 64'h0000_0000_0000_0000;
                  // Known element with a foreign length is rejected
                  el_bad_reg <= known_id && (RX_DATA != want_len);
                  if (known_id && RX_DATA != want_len) begin
                     frame_bad_reg <= 1'b1;
                  end
                  if (RX_DATA == 8'h00) begin
                     rx_state_reg <= auth_codec_pkg::RX_ID;
                  end else begin
                     rx_state_reg <= known_id ? auth_codec_pkg::RX_BODY : auth_codec_pkg::RX_DROP;
                  end
               end
               auth_codec_pkg::RX_BODY: begin
                  el_shift_reg <= {el_shift_reg[55:0], RX_DATA};
                  el_left_reg <= el_left_reg - 8'h01;
                  if (el_left_reg == 8'h01) begin
                     rx_state_reg <= auth_codec_pkg::RX_ID;
                     if (!el_bad_reg) begin
                        case (el_id_reg)
                           `EI_KEY_TYPE: RX_KEY_TYPE <= {el_shift_reg[15:0], RX_DATA};
                           `EI_SEED: RX_SEED <= {el_shift_reg[55:0], RX_DATA};
                           `EI_CHALLENGE: RX_CHALLENGE <= {el_shift_reg[55:0], RX_DATA};
                           `EI_RESPONSE: RX_RESPONSE <= {el_shift_reg[23:0], RX_DATA};
                           default: RX_SEED <= RX_SEED;
                        endcase
                     end
                  end
               end
               auth_codec_pkg::RX_DROP: begin
                  // Unrelated element: counted past, contents ignored
                  el_left_reg <= el_left_reg - 8'h01;
                  if (el_left_reg == 8'h01) begin
                     rx_state_reg <= auth_codec_pkg::RX_ID;
                  end
               end
               default: rx_state_reg <= auth_codec_pkg::RX_TYPE;
            endcase
            if (rx_end) begin
               rx_state_reg <= auth_codec_pkg::RX_TYPE;
               RX_HAS_RESPONSE <= seen_next[3];
               // End on a type or length octet, inside content, or a missing element is an error
               if (frame_bad_reg || !need_ok || rx_state_reg == auth_codec_pkg::RX_TYPE ||
                   rx_state_reg == auth_codec_pkg::RX_LEN ||
                   ((rx_state_reg == auth_codec_pkg::RX_BODY || rx_state_reg == auth_codec_pkg::RX_DROP) &&
                    el_left_reg != 8'h01) || el_bad_reg) begin
                  RX_ERROR <= 1'b1;
               end else begin
                  RX_DONE <= 1'b1;
               end
            end
         end
      end
   end

   // Response check on a clean reply; one-cycle release pulse on mismatch
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         RELEASE_CALL <= 1'b0;
      end else begin
         RELEASE_CALL <= RX_DONE && RX_IS_REPLY && (RX_RESPONSE != EXPECTED_RESPONSE);
      end
   end

   // Key binding tables: index is the key number, so each key is selectable
   logic [7:0] ak_identity [0:`KEY_ENTRIES-1];
   logic [`KEY_ENTRIES-1:0] ak_park;
   logic [`KEY_ENTRIES-1:0] ak_pin;
   logic [`KEY_ENTRIES-1:0] ak_valid;
   logic [7:0] ck_identity [0:`KEY_ENTRIES-1];
   logic [`KEY_ENTRIES-1:0] ck_park;
   logic [`KEY_ENTRIES-1:0] ck_valid;

   genvar g;
   generate
      for (g = 0; g < `KEY_ENTRIES; g++) begin : g_key
         // Authentication key entry; a second personal value for the same identity is refused
         always_ff @(posedge CLK) begin
            if (!RESET_N) begin
               ak_identity[g] <= `IDENTITY_RESET;
               ak_park[g] <= 1'b0;
               ak_pin[g] <= 1'b0;
               ak_valid[g] <= 1'b0;
            end else if (KEY_WRITE && !KEY_CIPHER && KEY_NUM == 2'(g)) begin
               if (!(KEY_PIN_BIND && ak_pin[g] && ak_identity[g] == KEY_IDENTITY)) begin
                  ak_identity[g] <= KEY_IDENTITY;
                  ak_park[g] <= KEY_WITH_PARK;
                  ak_pin[g] <= KEY_PIN_BIND;
                  ak_valid[g] <= 1'b1;
               end
            end
         end
         // Cipher key entry: static write or copy from an authentication key
         always_ff @(posedge CLK) begin
            if (!RESET_N) begin
               ck_identity[g] <= `IDENTITY_RESET;
               ck_park[g] <= 1'b0;
               ck_valid[g] <= 1'b0;
            end else if (KEY_DERIVE && KEY_NUM == 2'(g) && ak_valid[KEY_SRC_NUM]) begin
               ck_identity[g] <= ak_identity[KEY_SRC_NUM];
               ck_park[g] <= ak_park[KEY_SRC_NUM];
               ck_valid[g] <= 1'b1;
            end else if (KEY_WRITE && KEY_CIPHER && !KEY_DERIVE && KEY_NUM == 2'(g)) begin
               ck_identity[g] <= KEY_IDENTITY;
               ck_park[g] <= KEY_WITH_PARK;
               ck_valid[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // Refusal pulse and selected-key readout
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         KEY_REFUSED <= 1'b0;
         SEL_IDENTITY <= `IDENTITY_RESET;
         SEL_WITH_PARK <= 1'b0;
         SEL_PIN_BOUND <= 1'b0;
         SEL_VALID <= 1'b0;
      end else begin
         KEY_REFUSED <= (KEY_WRITE && !KEY_CIPHER && KEY_PIN_BIND && ak_pin[KEY_NUM] &&
                         ak_identity[KEY_NUM] == KEY_IDENTITY) ||
                        (KEY_DERIVE && !ak_valid[KEY_SRC_NUM]);
         SEL_IDENTITY <= KEY_SEL_CIPHER ? ck_identity[KEY_SEL] : ak_identity[KEY_SEL];
         SEL_WITH_PARK <= KEY_SEL_CIPHER ? ck_park[KEY_SEL] : ak_park[KEY_SEL];
         SEL_PIN_BOUND <= KEY_SEL_CIPHER ? 1'b0 : ak_pin[KEY_SEL];
         SEL_VALID <= KEY_SEL_CIPHER ? ck_valid[KEY_SEL] : ak_valid[KEY_SEL];
      end
   end
endmodule : auth_message_codec
`default_nettype wire

// [dv/peer_link_model.sv]
`timescale 1ns/1ns
`default_nettype none
module peer_link_model (
   // Clock
   input wire logic clk,
   // Codec transmit side
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_last,
   output logic tx_ready,
   // Codec receive side
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_last,
   // Stall every other cycle when high
   input wire logic slow
);
   logic [7:0] got [64];
   int n_got = 0;
   int last_at = -1;
   initial begin
      tx_ready = 1'b0;
      rx_data = 8'h00;
      rx_valid = 1'b0;
      rx_last = 1'b0;
   end
   // Ready toggles in slow mode so every byte after an accepted one sees a stall
   always @(posedge clk) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready && n_got < 64) begin
         got[n_got] <= tx_data;
         if (tx_last) last_at <= n_got;
         n_got <= n_got + 1;
      end
   end
   // Sends whole frames; a released line shows the inverse of its last byte
   task automatic send(input logic [7:0] q[$]);
      for (int i = 0; i < q.size(); i++) begin
         @(posedge clk);
         rx_data <= q[i];
         rx_valid <= 1'b1;
         rx_last <= (i == q.size() - 1);
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~q[q.size() - 1];
   endtask : send
endmodule : peer_link_model
`default_nettype wire

// [dv/auth_message_codec_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module auth_message_codec_assertions (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // Build and transmit
   input wire logic IS_FIXED_SIDE,
   input wire logic BUILD_START,
   input wire logic BUILD_BUSY,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_VALID,
   input wire logic TX_LAST,
   input wire logic TX_READY,
   // Receive and check
   input wire logic RX_VALID,
   input wire logic RX_LAST,
   input wire logic RX_DONE,
   input wire logic RX_ERROR,
   input wire logic RX_IS_REPLY,
   input wire logic [31:0] RX_RESPONSE,
   input wire logic [31:0] EXPECTED_RESPONSE,
   input wire logic RELEASE_CALL,
   // Keys
   input wire logic KEY_WRITE,
   input wire logic KEY_DERIVE,
   input wire logic KEY_REFUSED
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   logic [5:0] idx_reg;
   logic req_reg;
   // Byte position in the outgoing frame
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         idx_reg <= 6'h00;
         req_reg <= 1'b0;
      end else if (TX_VALID && TX_READY) begin
         idx_reg <= TX_LAST ? 6'h00 : idx_reg + 6'h01;
         if (idx_reg == 6'h00) begin
            req_reg <= (TX_DATA == 8'h40);
         end
      end
   end
   a_type_code: assert property (TX_VALID && idx_reg == 0 |-> TX_DATA == 8'h40 || TX_DATA == 8'h41)
      else $error("bad message type octet");
   a_start_answer: assert property (BUILD_START && !BUILD_BUSY |=> TX_VALID)
      else $error("build start not answered");
   a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
      else $error("byte changed while stalled");
   a_req_key_id: assert property (TX_VALID && idx_reg == 1 && req_reg |-> TX_DATA == 8'h0A)
      else $error("request does not open with key type");
   a_req_key_len: assert property (TX_VALID && idx_reg == 2 && req_reg |-> TX_DATA == 8'h03)
      else $error("key type length wrong");
   a_reply_first: assert property (TX_VALID && idx_reg == 1 && !req_reg |-> TX_DATA == (IS_FIXED_SIDE ? 8'h0E : 8'h0D))
      else $error("reply first element wrong");
   a_done_error: assert property ((RX_DONE || RX_ERROR) |-> !(RX_DONE && RX_ERROR) && $past(RX_VALID && RX_LAST))
      else $error("parse result not tied to frame end");
   a_release_cause: assert property (RX_DONE && RX_IS_REPLY && RX_RESPONSE != EXPECTED_RESPONSE |=> RELEASE_CALL)
      else $error("mismatch did not release call");
   a_release_only: assert property (RELEASE_CALL |-> $past(RX_DONE) && $past(RX_IS_REPLY))
      else $error("call released without reply");
   a_key_refuse: assert property (KEY_REFUSED |-> $past(KEY_WRITE || KEY_DERIVE))
      else $error("refusal without key request");
   c_release: cover property (RELEASE_CALL);
   c_rx_error: cover property (RX_ERROR);
   c_refused: cover property (KEY_REFUSED);
endmodule : auth_message_codec_assertions
bind auth_message_codec auth_message_codec_assertions chk_i (.CLK, .RESET_N, .IS_FIXED_SIDE, .BUILD_START,
   .BUILD_BUSY, .TX_DATA, .TX_VALID, .TX_LAST, .TX_READY, .RX_VALID, .RX_LAST, .RX_DONE, .RX_ERROR,
   .RX_IS_REPLY, .RX_RESPONSE, .EXPECTED_RESPONSE, .RELEASE_CALL, .KEY_WRITE, .KEY_DERIVE, .KEY_REFUSED);
`default_nettype wire

// [dv/auth_message_codec_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module auth_message_codec_tb_top;
   // Stimulus
   logic CLK = 0, RESET_N = 0, IS_FIXED_SIDE = 0, BUILD_START = 0, BUILD_REPLY = 0, BUILD_KEY_ALLOC = 0, SLOW = 0;
   logic [23:0] BUILD_KEY_TYPE = 24'h12_3456;
   logic [63:0] BUILD_CHALLENGE = 64'h0123_4567_89AB_CDEF, BUILD_SEED = 64'hFEDC_BA98_7654_3210;
   logic [31:0] BUILD_RESPONSE = 32'h1357_9BDF, EXPECTED_RESPONSE = 32'h0000_0000;
   logic KEY_WRITE = 0, KEY_CIPHER = 0, KEY_DERIVE = 0, KEY_WITH_PARK = 0, KEY_PIN_BIND = 0, KEY_SEL_CIPHER = 0;
   logic [1:0] KEY_NUM = 0, KEY_SRC_NUM = 0, KEY_SEL = 0;
   logic [7:0] KEY_IDENTITY = 8'h00;
   // Observed
   logic BUILD_BUSY, TX_VALID, TX_LAST, TX_READY, RX_VALID, RX_LAST, RX_DONE, RX_ERROR, RX_IS_REPLY;
   logic RX_HAS_RESPONSE, RELEASE_CALL, KEY_REFUSED, SEL_WITH_PARK, SEL_PIN_BOUND, SEL_VALID;
   logic [7:0] TX_DATA, RX_DATA, SEL_IDENTITY;
   logic [23:0] RX_KEY_TYPE;
   logic [63:0] RX_CHALLENGE, RX_SEED;
   logic [31:0] RX_RESPONSE;
   logic [7:0] fq[$];
   int n_fail = 0, checked = 0;
   auth_message_codec dut (.CLK, .RESET_N, .IS_FIXED_SIDE, .BUILD_START, .BUILD_REPLY, .BUILD_KEY_ALLOC,
      .BUILD_KEY_TYPE, .BUILD_CHALLENGE, .BUILD_SEED, .BUILD_RESPONSE, .BUILD_BUSY, .TX_DATA, .TX_VALID,
      .TX_LAST, .TX_READY, .RX_DATA, .RX_VALID, .RX_LAST, .RX_DONE, .RX_ERROR, .RX_IS_REPLY, .RX_KEY_TYPE,
      .RX_CHALLENGE, .RX_SEED, .RX_RESPONSE, .RX_HAS_RESPONSE, .EXPECTED_RESPONSE, .RELEASE_CALL, .KEY_WRITE,
      .KEY_CIPHER, .KEY_DERIVE, .KEY_NUM, .KEY_SRC_NUM, .KEY_IDENTITY, .KEY_WITH_PARK, .KEY_PIN_BIND,
      .KEY_REFUSED, .KEY_SEL, .KEY_SEL_CIPHER, .SEL_IDENTITY, .SEL_WITH_PARK, .SEL_PIN_BOUND, .SEL_VALID);
   peer_link_model peer (.clk(CLK), .tx_data(TX_DATA), .tx_valid(TX_VALID), .tx_last(TX_LAST),
      .tx_ready(TX_READY), .rx_data(RX_DATA), .rx_valid(RX_VALID), .rx_last(RX_LAST), .slow(SLOW));
   initial forever #2 CLK = ~CLK;
   task automatic close_out;
      $display("Counts: %0d checked, %0d failed", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Element: id, content length, content MSB first
   task automatic el(input logic [7:0] id, input int n, input logic [63:0] v);
      fq.push_back(id);
      fq.push_back(8'(n));
      for (int i = n - 1; i >= 0; i--) fq.push_back(v[8*i+:8]);
   endtask : el
   // Frame as the given originator must build it
   task automatic mk(input logic fx, input logic rep, input logic al);
      fq = {};
      fq.push_back(rep ? 8'h41 : 8'h40);
      if (!rep) el(8'h0A, 3, 64'(BUILD_KEY_TYPE));
      if (fx) el(8'h0E, 8, BUILD_SEED);
      if (!rep) el(8'h0C, 8, BUILD_CHALLENGE);
      if (rep || (!fx && al)) el(8'h0D, 4, 64'(BUILD_RESPONSE));
   endtask : mk
   // Strap passes two flops before it counts
   task automatic set_role(input logic fx, input logic [31:0] er);
      @(posedge CLK);
      IS_FIXED_SIDE <= fx;
      EXPECTED_RESPONSE <= er;
      repeat (3) @(posedge CLK);
   endtask : set_role
   task automatic build(input logic fx, input logic rep, input logic al);
      int k;
      mk(fx, rep, al);
      @(posedge CLK);
      peer.n_got = 0;
      SLOW <= ~SLOW;
      BUILD_REPLY <= rep;
      BUILD_KEY_ALLOC <= al;
      BUILD_START <= 1'b1;
      @(posedge CLK);
      BUILD_START <= 1'b0;
      for (k = 0; k < 200 && (peer.n_got < fq.size() || BUILD_BUSY !== 1'b0); k++) @(posedge CLK);
      if (k == 200) begin
         chk("build timeout", 1, 0);
         close_out();
      end
      chk("frame length", peer.n_got, fq.size());
      foreach (fq[i]) chk("frame byte", peer.got[i], fq[i]);
      chk("last flag position", peer.last_at, fq.size() - 1);
      $display("test build fixed=%0d reply=%0d alloc=%0d done", fx, rep, al);
   endtask : build
   // Sends fq, then waits for the parse result and the release pulse after it
   task automatic rx_run(output logic d, output logic e, output logic r);
      peer.send(fq);
      d = 0;
      e = 0;
      for (int k = 0; k < 8 && !(d || e); k++) begin
         #1;
         d = RX_DONE;
         e = RX_ERROR;
         @(posedge CLK);
      end
      if (!(d || e)) begin
         chk("parse timeout", 1, 0);
         close_out();
      end
      #1;
      r = RELEASE_CALL;
   endtask : rx_run
   task automatic t_rx;
      logic d, e, r;
      set_role(1'b1, BUILD_RESPONSE ^ 32'h0000_0001);
      mk(1'b0, 1'b0, 1'b0);
      fq.insert(1, 8'h55);
      fq.insert(1, 8'h01);
      fq.insert(1, 8'h7E);
      rx_run(d, e, r);
      chk("rx done", d, 1);
      chk("rx challenge", RX_CHALLENGE, BUILD_CHALLENGE);
      chk("rx key type", RX_KEY_TYPE, BUILD_KEY_TYPE);
      chk("rx no response", RX_HAS_RESPONSE, 0);
      mk(1'b0, 1'b0, 1'b0);
      fq[2] = 8'h02;
      rx_run(d, e, r);
      chk("bad length", e, 1);
      mk(1'b0, 1'b0, 1'b0);
      fq[0] = 8'hC0;
      rx_run(d, e, r);
      chk("bad type", e, 1);
      mk(1'b0, 1'b1, 1'b0);
      rx_run(d, e, r);
      chk("reply flag", RX_IS_REPLY, 1);
      chk("release on mismatch", r, 1);
      chk("rx response", RX_RESPONSE, BUILD_RESPONSE);
      chk("rx has response", RX_HAS_RESPONSE, 1);
      set_role(1'b0, BUILD_RESPONSE);
      mk(1'b1, 1'b1, 1'b0);
      rx_run(d, e, r);
      chk("seed", RX_SEED, BUILD_SEED);
      chk("no release on match", {d, r}, 2'b10);
      mk(1'b0, 1'b1, 1'b0);
      rx_run(d, e, r);
      chk("reply missing seed", e, 1);
      set_role(1'b0, BUILD_RESPONSE ^ 32'h0000_0001);
      mk(1'b1, 1'b1, 1'b0);
      rx_run(d, e, r);
      chk("second response mismatch", r, 1);
      $display("test receive done");
   endtask : t_rx
   task automatic key(input logic c, dv, input logic [1:0] n, s, input logic [7:0] id, input logic pk, pin, rf);
      @(posedge CLK);
      KEY_WRITE <= !dv;
      KEY_DERIVE <= dv;
      KEY_CIPHER <= c;
      KEY_NUM <= n;
      KEY_SRC_NUM <= s;
      KEY_IDENTITY <= id;
      KEY_WITH_PARK <= pk;
      KEY_PIN_BIND <= pin;
      @(posedge CLK);
      KEY_WRITE <= 1'b0;
      KEY_DERIVE <= 1'b0;
      #1;
      chk("key refused", KEY_REFUSED, rf);
   endtask : key
   task automatic sel(input logic c, input logic [1:0] n, input logic [7:0] id, input logic pk, pin, v);
      @(posedge CLK);
      KEY_SEL <= n;
      KEY_SEL_CIPHER <= c;
      @(posedge CLK);
      #1;
      chk("sel valid", SEL_VALID, v);
      if (v) chk("sel binding", {SEL_IDENTITY, SEL_WITH_PARK}, {id, pk});
      if (v && !c) chk("sel pin", SEL_PIN_BOUND, pin);
   endtask : sel
   task automatic t_keys;
      sel(0, 3, 0, 0, 0, 0);
      key(0, 0, 1, 0, 8'h05, 1, 1, 0);
      sel(0, 1, 8'h05, 1, 1, 1);
      key(0, 0, 2, 0, 8'h05, 0, 0, 0);
      sel(0, 2, 8'h05, 0, 0, 1);
      sel(0, 1, 8'h05, 1, 1, 1);
      key(0, 0, 1, 0, 8'h05, 1, 1, 1);
      key(1, 1, 0, 1, 8'h00, 0, 0, 0);
      sel(1, 0, 8'h05, 1, 0, 1);
      key(1, 1, 1, 3, 8'h00, 0, 0, 1);
      key(1, 0, 3, 0, 8'h09, 1, 0, 0);
      sel(1, 3, 8'h09, 1, 0, 1);
      key(1, 0, 2, 0, 8'h09, 0, 0, 0);
      sel(1, 2, 8'h09, 0, 0, 1);
      $display("test keys done");
   endtask : t_keys
   initial begin
      repeat (10) @(posedge CLK);
      RESET_N <= 1'b1;
      t_keys();
      for (int f = 0; f < 2; f++) begin
         set_role(f[0], 32'h0000_0000);
         build(f[0], 1'b0, 1'b0);
         build(f[0], 1'b0, 1'b1);
         build(f[0], 1'b1, 1'b0);
      end
      t_rx();
      close_out();
   end
endmodule : auth_message_codec_tb_top
`default_nettype wire
